// ### core/lpm_pkg.sv
// constants, encodings and carrier types of the low-power mode controller
package lpm_pkg;
	// register map, byte addresses on the bus
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_BKP_BASE = 8'h40;
	localparam int BKP_BYTES = 80;
	localparam int BKP_WORDS = BKP_BYTES / 4;
	localparam logic [7:0] OFS_BKP_LAST = 8'h8C;
	// control fields and reset value
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_REG_LP_BIT = 2;
	localparam int CTRL_BKSRAM_BIT = 3;
	localparam int CTRL_WKPIN_EN_BIT = 4;
	localparam int CTRL_W = 5;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	// low-power mode selected for the next core wait
	localparam logic [1:0] MODE_SLEEP = 2'h0;
	localparam logic [1:0] MODE_STOP = 2'h1;
	localparam logic [1:0] MODE_STANDBY = 2'h2;
	// interrupt status bits
	localparam int IRQ_SLEEP_WAKE = 0;
	localparam int IRQ_STOP_WAKE = 1;
	localparam int IRQ_STANDBY_EXIT = 2;
	localparam int IRQ_BATT_ON = 3;
	localparam int IRQ_BATT_OFF = 4;
	localparam int IRQ_W = 5;
	localparam logic [4:0] IRQ_RESET = 5'h00;
	// status fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_BATT_BIT = 8;
	// restart pulse after leaving standby or battery operation
	localparam int CLK_MHZ = 40;
	localparam int RESTART_TIME_NS = 1000;
	localparam int RESTART_CYCLES = (RESTART_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam logic [5:0] RESTART_LAST = 6'(RESTART_CYCLES - 1);
	// controller states, one-hot
	typedef enum logic [5:0] {
		ST_RUN = 6'b000001,
		ST_SLEEP = 6'b000010,
		ST_STOP = 6'b000100,
		ST_STANDBY = 6'b001000,
		ST_RESTART = 6'b010000,
		ST_BATTERY = 6'b100000
	} lpm_state_t;
	// event lines able to end stop mode
	typedef struct packed {
		logic [15:0] ext_line;
		logic voltage_detector_output;
		logic [3:0] rtc_evt; // alarm, wakeup, tamper, timestamp
		logic usb_wakeup;
		logic eth_wakeup;
	} wake_src_t;
	// clock, oscillator and supply controls
	typedef struct packed {
		logic core_clk_en;
		logic periph_clk_en;
		logic pll_en;
		logic internal_rc_oscillator_en;
		logic crystal_oscillator_en;
		logic regulator_on;
		logic regulator_lp;
		logic rtc_wdg_clk_en;
	} power_ctl_t;
	localparam power_ctl_t PWR_RUN = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
endpackage

// ### core/low_power_mode_controller.sv
// low-power mode and backup-domain controller with wishbone register slave
// Contract
// - sleep halts core only, peripherals keep clocks
// - any peripheral interrupt wakes core from sleep
// - stop gates core clocks, pll and oscillators
// - stop keeps sram and register contents
// - stop regulator mode normal or low-power selectable
// - any external event line ends stop mode
// - standby switches regulator, pll, oscillators off
// - standby loses core state except backup domain
// - standby exits on reset, watchdog, pin, rtc
// - rtc, watchdog and their clocks always run
// - twenty 32-bit backup registers, 80 bytes
// - backup registers survive system reset and standby
// - backup domain switches to battery without supply
// - on battery, wake events never leave battery operation
// - regulator-disable high makes port a bit zero reset
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module low_power_mode_controller
(
	// clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic backup_domain_rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// processor core
	input wire logic core_wait_i,
	input wire logic periph_irq_i,
	output logic core_halt_o,
	output logic core_rst_o,
	// wake and reset sources
	input wire lpm_pkg::wake_src_t wake_src_i,
	input wire logic external_reset_pin_n_i,
	input wire logic independent_watchdog_rst_i,
	input wire logic wakeup_pin_i,
	input wire logic regulator_disable_pin_i,
	input wire logic port_a_bit_zero_i,
	// supplies
	input wire logic main_supply_ok_i,
	output logic battery_supply_sel_o,
	output logic backup_sram_retain_o,
	// clocks, oscillators, regulator
	output lpm_pkg::power_ctl_t power_ctl_o,
	// interrupt
	output logic irq_o
);
	lpm_pkg::lpm_state_t state_r;
	lpm_pkg::lpm_state_t state_nxt;
	logic [lpm_pkg::CTRL_W-1:0] ctrl_r;
	logic [lpm_pkg::IRQ_W-1:0] irq_stat_r;
	logic [lpm_pkg::IRQ_W-1:0] irq_mask_r;
	logic [lpm_pkg::IRQ_W-1:0] irq_set;
	logic [31:0] bkp_r [lpm_pkg::BKP_WORDS];
	logic [5:0] restart_cnt_r;
	logic wakeup_pin_prev_r;
	logic on_batt_r;
	logic bkp_sram_sel_r;
	logic [1:0] mode_sel;
	logic stop_wake;
	logic standby_wake;
	logic hard_reset;
	logic lose_core;
	logic bus_req;
	logic wr_en;
	logic bkp_hit;
	logic [4:0] bkp_idx;
	logic [7:0] bkp_ofs;
	logic [31:0] wmask;
	logic [31:0] rd_data;

	// bus request decode; registers answer one cycle after the request
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_en = bus_req & wb_we_i;
	assign bkp_ofs = wb_adr_i - lpm_pkg::OFS_BKP_BASE;
	assign bkp_idx = bkp_ofs[6:2];
	assign bkp_hit = (wb_adr_i >= lpm_pkg::OFS_BKP_BASE) && (wb_adr_i <= lpm_pkg::OFS_BKP_LAST)
		&& (wb_adr_i[1:0] == 2'h0);
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign mode_sel = ctrl_r[lpm_pkg::CTRL_MODE_LSB +: 2];

	// wake sources per mode
	// any event line ends stop
	assign stop_wake = |wake_src_i;
	// standby exit sources, pin on rising edge
	assign standby_wake = (|wake_src_i.rtc_evt) | (wakeup_pin_i & ~wakeup_pin_prev_r)
		| ~external_reset_pin_n_i | independent_watchdog_rst_i;
	// port a bit zero as internal reset
	assign hard_reset = ~external_reset_pin_n_i | independent_watchdog_rst_i
		| (regulator_disable_pin_i & ~port_a_bit_zero_i);
	// core domain is wiped when restarting from an unpowered state
	assign lose_core = (state_r == lpm_pkg::ST_STANDBY || state_r == lpm_pkg::ST_BATTERY)
		&& state_nxt == lpm_pkg::ST_RESTART;

	// mode sequencing
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			lpm_pkg::ST_RUN:
			begin
				if (core_wait_i)
				begin
					if (mode_sel == lpm_pkg::MODE_STOP)
						state_nxt = lpm_pkg::ST_STOP;
					else if (mode_sel == lpm_pkg::MODE_STANDBY)
						state_nxt = lpm_pkg::ST_STANDBY;
					else
						state_nxt = lpm_pkg::ST_SLEEP;
				end
			end
			lpm_pkg::ST_SLEEP:
			begin
				if (periph_irq_i | stop_wake)
					state_nxt = lpm_pkg::ST_RUN;
			end
			lpm_pkg::ST_STOP:
			begin
				// back to run with state kept
				if (stop_wake)
					state_nxt = lpm_pkg::ST_RUN;
			end
			lpm_pkg::ST_STANDBY:
			begin
				if (standby_wake)
					state_nxt = lpm_pkg::ST_RESTART;
			end
			lpm_pkg::ST_RESTART:
			begin
				if (restart_cnt_r == lpm_pkg::RESTART_LAST)
					state_nxt = lpm_pkg::ST_RUN;
			end
			lpm_pkg::ST_BATTERY:
			begin
				// only returning supply ends battery operation
				if (main_supply_ok_i)
					state_nxt = lpm_pkg::ST_RESTART;
			end
			default:
				state_nxt = lpm_pkg::ST_RESTART;
		endcase
		// pin and watchdog resets restart from any powered state
		if (hard_reset && state_r != lpm_pkg::ST_BATTERY && state_r != lpm_pkg::ST_STANDBY)
			state_nxt = lpm_pkg::ST_RESTART;
		if (!main_supply_ok_i)
			state_nxt = lpm_pkg::ST_BATTERY;
	end

	// state register; power-on starts through the restart sequence
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_r <= lpm_pkg::ST_RESTART;
		else
			state_r <= state_nxt;
	end

	// restart length counter
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state_r != lpm_pkg::ST_RESTART)
			restart_cnt_r <= 6'h00;
		else if (restart_cnt_r != lpm_pkg::RESTART_LAST)
			restart_cnt_r <= restart_cnt_r + 6'h01;
	end

	// wakeup pin history for edge detect
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wakeup_pin_prev_r <= 1'b0;
		else
			wakeup_pin_prev_r <= wakeup_pin_i;
	end

	// control register; stop keeps it, standby and battery lose it
	always_ff @(posedge clk_i)
	begin
		if (rst_i || lose_core)
			ctrl_r <= lpm_pkg::CTRL_RESET;
		else if (wr_en && wb_adr_i == lpm_pkg::OFS_CTRL && wb_sel_i[0])
			ctrl_r <= wb_dat_i[lpm_pkg::CTRL_W-1:0];
	end

	// backup sram retention select lives in the backup domain
	always_ff @(posedge clk_i)
	begin
		if (backup_domain_rst_i)
			bkp_sram_sel_r <= 1'b0;
		else if (wr_en && wb_adr_i == lpm_pkg::OFS_CTRL && wb_sel_i[0])
			bkp_sram_sel_r <= wb_dat_i[lpm_pkg::CTRL_BKSRAM_BIT];
	end

	// backup registers, cleared only by a backup-domain reset
	// twenty words with byte lanes
	// system reset has no effect here
	always_ff @(posedge clk_i)
	begin
		if (backup_domain_rst_i)
		begin
			for (int i = 0; i < lpm_pkg::BKP_WORDS; i++)
				bkp_r[i] <= 32'h00000000;
		end
		else if (wr_en && bkp_hit)
			bkp_r[bkp_idx] <= (bkp_r[bkp_idx] & ~wmask) | (wb_dat_i & wmask);
	end

	// battery flag; the supply input is taken as already debounced
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			on_batt_r <= 1'b0;
		else
			on_batt_r <= ~main_supply_ok_i;
	end

	// interrupt events from the mode sequencer and the supply switch
	always_comb
	begin
		irq_set = '0;
		irq_set[lpm_pkg::IRQ_SLEEP_WAKE] = state_r == lpm_pkg::ST_SLEEP && state_nxt == lpm_pkg::ST_RUN;
		irq_set[lpm_pkg::IRQ_STOP_WAKE] = state_r == lpm_pkg::ST_STOP && state_nxt == lpm_pkg::ST_RUN;
		irq_set[lpm_pkg::IRQ_STANDBY_EXIT] = state_r == lpm_pkg::ST_STANDBY
			&& state_nxt == lpm_pkg::ST_RESTART;
		irq_set[lpm_pkg::IRQ_BATT_ON] = ~main_supply_ok_i & ~on_batt_r;
		irq_set[lpm_pkg::IRQ_BATT_OFF] = main_supply_ok_i & on_batt_r;
	end

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_stat_r <= lpm_pkg::IRQ_RESET;
		else if (lose_core)
			irq_stat_r <= irq_set;
		else if (wr_en && wb_adr_i == lpm_pkg::OFS_IRQ_STAT && wb_sel_i[0])
			irq_stat_r <= (irq_stat_r & ~wb_dat_i[lpm_pkg::IRQ_W-1:0]) | irq_set;
		else
			irq_stat_r <= irq_stat_r | irq_set;
	end

	// interrupt mask, core-domain register
	always_ff @(posedge clk_i)
	begin
		if (rst_i || lose_core)
			irq_mask_r <= lpm_pkg::IRQ_RESET;
		else if (wr_en && wb_adr_i == lpm_pkg::OFS_IRQ_MASK && wb_sel_i[0])
			irq_mask_r <= wb_dat_i[lpm_pkg::IRQ_W-1:0];
	end

	// interrupt output level
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_stat_r & irq_mask_r);
	end

	// read mux; unmapped addresses read zero and still acknowledge
	always_comb
	begin
		rd_data = 32'h00000000;
		if (wb_adr_i == lpm_pkg::OFS_CTRL)
		begin
			rd_data[lpm_pkg::CTRL_W-1:0] = ctrl_r;
			rd_data[lpm_pkg::CTRL_BKSRAM_BIT] = bkp_sram_sel_r;
		end
		else if (wb_adr_i == lpm_pkg::OFS_STATUS)
		begin
			rd_data[lpm_pkg::STAT_STATE_LSB +: 6] = state_r;
			rd_data[lpm_pkg::STAT_BATT_BIT] = on_batt_r;
		end
		else if (wb_adr_i == lpm_pkg::OFS_IRQ_STAT)
			rd_data[lpm_pkg::IRQ_W-1:0] = irq_stat_r;
		else if (wb_adr_i == lpm_pkg::OFS_IRQ_MASK)
			rd_data[lpm_pkg::IRQ_W-1:0] = irq_mask_r;
		else if (bkp_hit)
			rd_data = bkp_r[bkp_idx];
	end

	// bus answer registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_data : 32'h00000000;
		end
	end

	// core halt and reset outputs, registered from next state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			core_halt_o <= 1'b1;
			core_rst_o <= 1'b1;
		end
		else
		begin
			core_halt_o <= state_nxt != lpm_pkg::ST_RUN;
			// reset held through restart and unpowered states
			core_rst_o <= state_nxt == lpm_pkg::ST_RESTART || state_nxt == lpm_pkg::ST_STANDBY
				|| state_nxt == lpm_pkg::ST_BATTERY;
		end
	end

	// clock, oscillator and regulator controls per state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			power_ctl_o <= lpm_pkg::PWR_RUN;
		else
		begin
			power_ctl_o <= lpm_pkg::PWR_RUN;
			// rtc and watchdog clocks never gated
			power_ctl_o.rtc_wdg_clk_en <= 1'b1;
			unique case (state_nxt)
				lpm_pkg::ST_SLEEP:
				begin
					power_ctl_o.core_clk_en <= 1'b0;
				end
				lpm_pkg::ST_STOP:
				begin
					// core domain clocks and oscillators off
					power_ctl_o.core_clk_en <= 1'b0;
					power_ctl_o.periph_clk_en <= 1'b0;
					power_ctl_o.pll_en <= 1'b0;
					power_ctl_o.internal_rc_oscillator_en <= 1'b0;
					power_ctl_o.crystal_oscillator_en <= 1'b0;
					power_ctl_o.regulator_lp <= ctrl_r[lpm_pkg::CTRL_REG_LP_BIT];
				end
				lpm_pkg::ST_STANDBY, lpm_pkg::ST_BATTERY:
				begin
					power_ctl_o.core_clk_en <= 1'b0;
					power_ctl_o.periph_clk_en <= 1'b0;
					power_ctl_o.pll_en <= 1'b0;
					power_ctl_o.internal_rc_oscillator_en <= 1'b0;
					power_ctl_o.crystal_oscillator_en <= 1'b0;
					power_ctl_o.regulator_on <= 1'b0;
				end
				lpm_pkg::ST_RUN, lpm_pkg::ST_RESTART:
					power_ctl_o.regulator_lp <= 1'b0;
			endcase
		end
	end

	// backup domain supply switch and sram retention
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			battery_supply_sel_o <= 1'b0;
			backup_sram_retain_o <= 1'b0;
		end
		else
		begin
			// battery feeds backup domain without main supply
			battery_supply_sel_o <= ~main_supply_ok_i;
			backup_sram_retain_o <= bkp_sram_sel_r;
		end
	end
endmodule

// ### sim/lpm_monitor.sv
// port-level assertion checker for the low-power mode controller
`timescale 1ns/1ps
module lpm_monitor
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus handshake
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// core side and wake sources
	input wire logic core_wait_i,
	input wire logic periph_irq_i,
	input wire logic core_halt_o,
	input wire logic core_rst_o,
	input wire lpm_pkg::wake_src_t wake_src_i,
	input wire logic external_reset_pin_n_i,
	input wire logic independent_watchdog_rst_i,
	input wire logic regulator_disable_pin_i,
	input wire logic port_a_bit_zero_i,
	// supplies and power controls
	input wire logic main_supply_ok_i,
	input wire logic battery_supply_sel_o,
	input wire lpm_pkg::power_ctl_t power_ctl_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic calm;
	logic [15:0] rst_len_r;
	// no hard reset and supply present, so only the wake paths can act
	assign calm = external_reset_pin_n_i && !independent_watchdog_rst_i && main_supply_ok_i
		&& !(regulator_disable_pin_i && !port_a_bit_zero_i);
	// length of the current core reset; battery time only lengthens it
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !core_rst_o)
			rst_len_r <= 16'h0000;
		else
			rst_len_r <= rst_len_r + 16'h0001;
	end
	// state signatures seen from the outputs alone
	sequence s_run_wait; !core_halt_o && !core_rst_o && core_wait_i && calm; endsequence
	sequence s_sleep; core_halt_o && !core_rst_o && power_ctl_o.periph_clk_en; endsequence
	sequence s_stop; core_halt_o && !core_rst_o && !power_ctl_o.periph_clk_en; endsequence
	a_bus_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_bus_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_enter_halt: assert property (s_run_wait |=> core_halt_o && !power_ctl_o.core_clk_en)
		else $error("wait request did not halt the core");
	a_sleep_keeps: assert property (s_sleep |-> power_ctl_o.pll_en && power_ctl_o.crystal_oscillator_en
		&& power_ctl_o.internal_rc_oscillator_en && power_ctl_o.regulator_on)
		else $error("sleep stopped more than the core");
	a_sleep_wake: assert property (s_sleep ##0 (periph_irq_i && calm) |=> !core_halt_o)
		else $error("interrupt did not end sleep");
	a_stop_gates: assert property (s_stop |-> !power_ctl_o.pll_en && !power_ctl_o.crystal_oscillator_en
		&& !power_ctl_o.internal_rc_oscillator_en && power_ctl_o.regulator_on)
		else $error("stop left a clock source running");
	a_stop_wake: assert property (s_stop ##0 (|wake_src_i && calm) |=> !core_halt_o
		&& power_ctl_o == lpm_pkg::PWR_RUN)
		else $error("event line did not end stop");
	a_clocks_alive: assert property (power_ctl_o.rtc_wdg_clk_en)
		else $error("rtc and watchdog clock stopped");
	a_batt_switch: assert property (battery_supply_sel_o == !$past(main_supply_ok_i))
		else $error("battery switch does not follow supply");
	a_batt_hold: assert property (!main_supply_ok_i [*2] |=> core_rst_o && core_halt_o)
		else $error("core left reset on battery");
	a_porta_reset: assert property (regulator_disable_pin_i && !port_a_bit_zero_i |-> ##[1:2] core_rst_o)
		else $error("port a reset not honoured");
	a_restart_len: assert property ($fell(core_rst_o) |-> rst_len_r >= lpm_pkg::RESTART_CYCLES - 1)
		else $error("restart shorter than its count");
endmodule
bind low_power_mode_controller lpm_monitor lpm_monitor_inst (.*);

// ### sim/wake_model.sv
// behavioural partner: core wait requests, interrupts and wake sources
`timescale 1ns/1ps
module wake_model
(
	// clock and bench command
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [1:0] kind_i,
	input wire logic [4:0] idx_i,
	// toward the controller
	output logic core_wait_o,
	output logic periph_irq_o,
	output lpm_pkg::wake_src_t wake_src_o,
	output logic wakeup_pin_o
);
	// one-cycle pulses; every line falls back to its low idle level
	always_ff @(posedge clk_i)
	begin
		core_wait_o <= go_i && kind_i == 2'h0;
		periph_irq_o <= go_i && kind_i == 2'h1;
		wake_src_o <= (go_i && kind_i == 2'h2) ? lpm_pkg::wake_src_t'(23'h000001 << idx_i) : '0;
		wakeup_pin_o <= go_i && kind_i == 2'h3;
	end
endmodule

// ### sim/low_power_mode_controller_tb.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/1ps
module low_power_mode_controller_tb;
	logic clk_i, rst_i, bkrst, cyc, stb, we, go, ext_rst_n, wdg, regulator_disable_pin, pa0, sup_ok;
	logic ack, halt, crst, bsel, keep, irq, cwait, pirq, wpin;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [1:0] kind;
	logic [4:0] idx;
	logic [31:0] wdat, rdat, seed;
	logic [31:0] bk [lpm_pkg::BKP_WORDS];
	logic [31:0] exp_q [$];
	lpm_pkg::wake_src_t wsrc;
	lpm_pkg::power_ctl_t pc;
	int failures, compares;
	low_power_mode_controller low_power_mode_controller_inst (.clk_i(clk_i), .rst_i(rst_i),
		.backup_domain_rst_i(bkrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .core_wait_i(cwait),
		.periph_irq_i(pirq), .core_halt_o(halt), .core_rst_o(crst), .wake_src_i(wsrc),
		.external_reset_pin_n_i(ext_rst_n), .independent_watchdog_rst_i(wdg), .wakeup_pin_i(wpin),
		.regulator_disable_pin_i(regulator_disable_pin), .port_a_bit_zero_i(pa0), .main_supply_ok_i(sup_ok),
		.battery_supply_sel_o(bsel), .backup_sram_retain_o(keep), .power_ctl_o(pc), .irq_o(irq));
	wake_model wake_model_inst (.clk_i(clk_i), .go_i(go), .kind_i(kind), .idx_i(idx),
		.core_wait_o(cwait), .periph_irq_o(pirq), .wake_src_o(wsrc), .wakeup_pin_o(wpin));
	// 40 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic close_out;
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// classic single cycle; holds everything until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1);
		{cyc, stb, we} <= 3'b000;
		// ack is registered, so it is sampled two edges after the request goes out
		chk(n, 2);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h00000000, 4'hF);
	endtask
	task automatic fire(input logic [1:0] k, input logic [4:0] i);
		@(posedge clk_i);
		{go, kind, idx} <= {1'b1, k, i};
		@(posedge clk_i);
		go <= 1'b0;
		tick(2);
	endtask
	// waits out a restart; the bound leaves room for the exit latency
	task automatic settle;
		int n;
		n = 0;
		while (crst !== 1'b0 && n < 200)
		begin
			@(posedge clk_i);
			n++;
		end
		chk(n > lpm_pkg::RESTART_CYCLES - 5 && n < lpm_pkg::RESTART_CYCLES + 3, 1);
	endtask
	task automatic bkchk;
		for (int i = 0; i < lpm_pkg::BKP_WORDS; i++)
			rd(lpm_pkg::OFS_BKP_BASE + 8'(4 * i), bk[i]);
	endtask
	// read data compared with the oldest noted expectation
	always @(posedge clk_i)
		if (ack === 1'b1 && we === 1'b0)
		begin
			// an unexpected read counts as a mismatch, even with unknown data
			if (exp_q.size() > 0)
				chk(rdat, exp_q.pop_front());
			else
				chk(32'h00000000, 32'h00000001);
		end
	// watchdog: whole sequence needs well under 10000 cycles
	initial
	begin
		#500000;
		failures++;
		close_out;
	end
	initial
	begin
		{failures, compares, seed, go, kind, idx, cyc, stb, we, adr, sel, wdat} = '0;
		seed = 32'h00000054;
		{ext_rst_n, wdg, regulator_disable_pin, pa0, sup_ok, rst_i, bkrst} = 7'b1001111;
		repeat (2) @(posedge clk_i);
		{rst_i, bkrst} <= 2'b00;
		settle;
		rd(lpm_pkg::OFS_CTRL, 32'h00000000);
		rd(lpm_pkg::OFS_IRQ_MASK, 32'h00000000);
		rd(lpm_pkg::OFS_STATUS, 32'h00000001);
		wr(8'h90, xs());
		rd(8'h90, 32'h00000000);
		// random backup fill, then one byte lane
		for (int i = 0; i < lpm_pkg::BKP_WORDS; i++)
		begin
			bk[i] = xs();
			wr(lpm_pkg::OFS_BKP_BASE + 8'(4 * i), bk[i]);
		end
		bus(1'b1, lpm_pkg::OFS_BKP_BASE, 32'hFFFFFFFF, 4'h2);
		bk[0][15:8] = 8'hFF;
		bkchk;
		// sleep with interrupt masked, then unmasked and cleared
		wr(lpm_pkg::OFS_CTRL, 32'(lpm_pkg::MODE_SLEEP));
		fire(2'h0, 5'h00);
		chk({halt, pc}, 9'h17D);
		fire(2'h1, 5'h00);
		chk({halt, irq}, 2'b00);
		rd(lpm_pkg::OFS_IRQ_STAT, 32'h1 << lpm_pkg::IRQ_SLEEP_WAKE);
		wr(lpm_pkg::OFS_IRQ_MASK, 32'h0000001F);
		tick(2);
		chk(irq, 1'b1);
		wr(lpm_pkg::OFS_IRQ_STAT, 32'h0000001F);
		tick(2);
		chk(irq, 1'b0);
		// stop ended by each event line in turn, regulator mode alternating
		for (int i = 0; i < 23; i++)
		begin
			wr(lpm_pkg::OFS_CTRL, {29'h0, i[0], lpm_pkg::MODE_STOP});
			fire(2'h0, 5'h00);
			chk({halt, pc}, {6'h20, 1'b1, i[0], 1'b1});
			fire(2'h2, 5'(i));
			chk({halt, pc}, {1'b0, lpm_pkg::PWR_RUN});
			rd(lpm_pkg::OFS_CTRL, {29'h0, i[0], lpm_pkg::MODE_STOP});
			rd(lpm_pkg::OFS_IRQ_STAT, 32'h1 << lpm_pkg::IRQ_STOP_WAKE);
			wr(lpm_pkg::OFS_IRQ_STAT, 32'h0000001F);
		end
		// standby with retention, left by each exit source
		for (int k = 0; k < 4; k++)
		begin
			wr(lpm_pkg::OFS_CTRL, 32'h0000000A);
			fire(2'h0, 5'h00);
			chk({pc.core_clk_en, pc.pll_en, pc.internal_rc_oscillator_en, pc.crystal_oscillator_en,
				pc.regulator_on, crst}, 6'h01);
			if (k < 2)
				fire(2'(k + 2), 5'h02);
			@(posedge clk_i);
			{ext_rst_n, wdg} <= {k != 2, k == 3};
			@(posedge clk_i);
			{ext_rst_n, wdg} <= 2'b10;
			settle;
			chk(keep, 1'b1);
			rd(lpm_pkg::OFS_CTRL, 32'h00000008);
			rd(lpm_pkg::OFS_IRQ_STAT, 32'h1 << lpm_pkg::IRQ_STANDBY_EXIT);
			bkchk;
		end
		// port a reset only counts with the regulator disabled
		@(posedge clk_i);
		pa0 <= 1'b0;
		tick(3);
		chk(crst, 1'b0);
		@(posedge clk_i);
		regulator_disable_pin <= 1'b1;
		@(posedge clk_i);
		{regulator_disable_pin, pa0} <= 2'b01;
		tick(2);
		chk(crst, 1'b1);
		settle;
		// system reset in mid-run keeps backup words
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		settle;
		bkchk;
		// battery: wakes ignored until supply returns
		sup_ok <= 1'b0;
		tick(3);
		chk({bsel, crst}, 2'b11);
		// battery state and the entry event stay visible on the bus
		rd(lpm_pkg::OFS_STATUS, 32'h00000120);
		rd(lpm_pkg::OFS_IRQ_STAT, 32'h1 << lpm_pkg::IRQ_BATT_ON);
		fire(2'h2, 5'h07);
		fire(2'h1, 5'h00);
		chk(crst, 1'b1);
		@(posedge clk_i);
		sup_ok <= 1'b1;
		settle;
		chk(bsel, 1'b0);
		rd(lpm_pkg::OFS_IRQ_STAT, 32'h1 << lpm_pkg::IRQ_BATT_OFF);
		bkchk;
		close_out;
	end
endmodule
